//--- rtl/ccs_map.vh
// register offsets, field positions, codes and reset values of the command sequencer
`ifndef CCS_MAP_VH
`define CCS_MAP_VH

// --------------------
// register byte offsets
// --------------------
`define CCS_OFS_CMD 8'h00
`define CCS_OFS_CTRL 8'h04
`define CCS_OFS_IRQ 8'h08
`define CCS_OFS_ERR 8'h0C
`define CCS_OFS_STAT 8'h10
`define CCS_OFS_FIFO 8'h14

// --------------------
// command codes
// --------------------
`define CCS_CMD_IDLE 4'h0
`define CCS_CMD_KEEP 4'h7
`define CCS_CMD_RECV 4'h8
`define CCS_CMD_TRCV 4'hC
`define CCS_CMD_ACOL 4'hD
`define CCS_CMD_AUTH 4'hE
`define CCS_CMD_SRST 4'hF

// --------------------
// command register fields
// --------------------
`define CCS_CMD_RXOFF 4
`define CCS_CMD_PDOWN 5

// --------------------
// control register fields
// --------------------
`define CCS_CTL_INIT 0
`define CCS_CTL_MULTI 1
`define CCS_CTL_TAUTO 2
`define CCS_CTL_MDOFF 3
`define CCS_CTL_TXCRC 4
`define CCS_CTL_RXCRC 5
`define CCS_CTL_SEND 6
`define CCS_CTL_RATE_LO 7
`define CCS_CTL_RATE_HI 8
`define CCS_CTL_LENFR 9
`define CCS_CTL_PEER 10
`define CCS_CTL_W 11
`define CCS_CTL_RST 11'h000

// --------------------
// interrupt flag and error flag positions
// --------------------
`define CCS_IRQ_TIMER 0
`define CCS_IRQ_IDLE 1
`define CCS_IRQ_RX 2
`define CCS_IRQ_TX 3
`define CCS_IRQ_RFON 4
`define CCS_IRQ_RFOFF 5
`define CCS_IRQ_SIGIN 6
`define CCS_IRQ_W 7
`define CCS_ERR_WR 0
`define CCS_ERR_PROT 1

// --------------------
// rates, detected modes and constants
// --------------------
`define CCS_RATE_106 2'h0
`define CCS_MODE_P106 3'h0
`define CCS_MODE_P212 3'h1
`define CCS_MODE_A106 3'h2
`define CCS_MODE_A212 3'h3
`define CCS_MODE_CARDA 3'h4
`define CCS_MODE_CARDF 3'h5
`define CCS_START_BYTE 8'hF0
`define CCS_AUTH_BYTES 7'h0C
`define CCS_AC_A_CRC 1'b0

`endif

//--- rtl/ccs_sync3.v
// three-flop input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps

module ccs_sync3 #(
	parameter W = 2
) (
	// clock and reset
	input wire clock_in,
	input wire reset_n_in,
	// asynchronous levels and filtered result
	input wire [W-1:0] async_in,
	output reg [W-1:0] level_out
);

reg [W-1:0] s1_r;
reg [W-1:0] s2_r;
reg [W-1:0] s3_r;
genvar i;

generate
	for (i = 0; i < W; i = i + 1) begin : g_bit
		always @(posedge clock_in or negedge reset_n_in) begin
			if (!reset_n_in) begin
				s1_r[i] <= 1'b0;
				s2_r[i] <= 1'b0;
				s3_r[i] <= 1'b0;
				level_out[i] <= 1'b0;
			end else begin
				s1_r[i] <= async_in[i];
				s2_r[i] <= s1_r[i];
				s3_r[i] <= s2_r[i];
				// a lone glitch in stage two never reaches the output
				if (s2_r[i] == s3_r[i]) begin
					level_out[i] <= s3_r[i];
				end
			end
		end
	end
endgenerate

endmodule

//--- rtl/ccs_sequencer.v
// command sequencer of the contactless interface unit with apb register access
`timescale 1ns/1ps
`include "ccs_map.vh"

//Contract
// [R1] four-bit command codes: idle, keep, receive, transceive, activation, authenticate, reset
// [R2] keep-command code only updates receiver-off and power-down bits
// [R3] receive enables receiver, ends itself at end of frame, then goes idle
// [R4] 212/424 length framing stops at length count, pads noise, drops surplus
// [R5] zero length byte discards the frame, reception keeps waiting
// [R6] 106 peer: ends at frame end; surplus restarts reception and timer
// [R7] no frame with auto-timer set raises timer flag; firmware ends reception
// [R8] multiple-receive: receive never self-ends, transceive stays receiving
// [R9] transceive alternates; initiator one sends first, zero receives first
// [R10] transceive reception also ends on field loss; nothing happens without field
// [R11] firmware starts each send with start-send and ends transceive by new code
// [R12] activation needs initiator zero (code starts it whatever the initiator bit is); mode detector runs unless disabled
// [R13] field loss during activation restarts its state machine, command stays
// [R14] activation only raises field and secure-input flags; ends in transceive; code also sets the rx flag on completion
// [R15] type A activation drives CRC enables internally; type F uses register bits
// [R16] 106 detected without anticollision keeps the two CRC bytes in FIFO
// [R17] other code cancels activation; rewriting activation code restarts it
// [R18] passive and card modes: target-activated set; 106 passive starts with F0
// [R19] active peer: target-activated cleared; 106 starts with F0 and keeps CRC
// [R20] firmware loads twelve FIFO bytes before authentication
// [R21] authentication blocks FIFO access with write error, holds rx/tx flags
// [R22] authentication success ends command and sets cipher-active
// [R23] authentication error sets protocol error and clears cipher-active
// [R24] soft reset restores register reset values, keeps config buffer, then idle
// [R25] any code but keep aborts the running command and starts the new one
module ccs_sequencer (
	// clock and reset
	input wire clock_in,
	input wire reset_n_in,
	// apb slave
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [7:0] paddr_in,
	input wire [31:0] pwdata_in,
	output reg [31:0] prdata_out,
	output reg pready_out,
	output reg pslverr_out,
	// receive and transmit datapath
	input wire rx_byte_valid_in,
	input wire [7:0] rx_byte_in,
	input wire rx_eof_in,
	input wire [7:0] rx_noise_in,
	input wire tx_done_in,
	output reg rx_enable_out,
	output reg tx_start_out,
	// field pins
	input wire rf_field_in,
	input wire sig_active_in,
	// timer
	input wire timer_expired_in,
	output reg timer_start_out,
	// activation engine
	input wire mode_detected_in,
	input wire [2:0] mode_in,
	input wire ac_done_in,
	input wire ac_ran_in,
	output reg mode_detect_en_out,
	output reg tx_crc_en_out,
	output reg rx_crc_en_out,
	output reg crc_keep_out,
	// authentication engine
	input wire [6:0] fifo_level_in,
	input wire auth_ok_in,
	input wire auth_err_in,
	output reg auth_start_out,
	// fifo
	input wire [7:0] fifo_rdata_in,
	output reg fifo_push_out,
	output reg [7:0] fifo_wdata_out,
	output reg fifo_pop_out,
	// misc
	output reg soft_reset_out,
	output reg power_down_out
);

// --------------------
// states
// --------------------
localparam ST_IDLE = 8'h01;
localparam ST_RX = 8'h02;
localparam ST_PAD = 8'h04;
localparam ST_TXW = 8'h08;
localparam ST_TX = 8'h10;
localparam ST_AC = 8'h20;
localparam ST_AUTH = 8'h40;
localparam ST_SRST = 8'h80;

reg [7:0] state_r, state_nxt;
reg [3:0] cmd_r, cmd_nxt;
reg rxoff_r, pdown_r;
reg [`CCS_CTL_W-1:0] ctrl_r;
reg [`CCS_IRQ_W-1:0] irq_r, irq_set;
reg [1:0] err_r, err_set;
reg cipher_r, tact_r;
reg [7:0] cnt_r, cnt_nxt, len_r, len_nxt;
reg first_r, first_nxt, drop_r, drop_nxt, surp_r, surp_nxt;
reg started_r, started_nxt;
reg acv_r, acv_nxt;
reg [2:0] acmode_r, acmode_nxt;
reg rf_d_r, sig_d_r;
reg push, txgo, tmgo, authgo, rx_done, send_clr, tact_set, tact_val;
reg [7:0] pdata;
reg [31:0] rd_mux;
wire [1:0] pins_flt;
wire rf_ok = pins_flt[0];
wire sig_ok = pins_flt[1];
wire [7:0] cnt_inc = cnt_r + 8'h01;
wire acc = psel_in & penable_in & pready_out;
wire apb_wr = acc & pwrite_in;
wire [3:0] wr_code = pwdata_in[3:0];
wire cmd_wr = apb_wr & (paddr_in == `CCS_OFS_CMD) & (wr_code != `CCS_CMD_KEEP); // R2
wire fifo_acc = acc & (paddr_in == `CCS_OFS_FIFO);
wire auth_act = (state_r == ST_AUTH);
wire rate106 = (ctrl_r[`CCS_CTL_RATE_HI:`CCS_CTL_RATE_LO] == `CCS_RATE_106);
wire lenmode = ctrl_r[`CCS_CTL_LENFR] & ~rate106;
wire peer106 = ctrl_r[`CCS_CTL_PEER] & rate106;
wire tauto = ctrl_r[`CCS_CTL_TAUTO];
wire multi = ctrl_r[`CCS_CTL_MULTI];
wire acm_a = (acmode_r == `CCS_MODE_P106) | (acmode_r == `CCS_MODE_A106) |
	(acmode_r == `CCS_MODE_CARDA);
wire acm_106 = (acmode_r == `CCS_MODE_P106) | (acmode_r == `CCS_MODE_A106);
wire addr_hit = (paddr_in <= `CCS_OFS_FIFO) & (paddr_in[1:0] == 2'b00);

ccs_sync3 #(
	.W(2)
) u_pins (
	.clock_in(clock_in),
	.reset_n_in(reset_n_in),
	.async_in({sig_active_in, rf_field_in}),
	.level_out(pins_flt)
);

// --------------------
// register read mux
// --------------------
always @* begin
	rd_mux = 32'h00000000;
	case (paddr_in)
	`CCS_OFS_CMD: rd_mux = {26'h0, pdown_r, rxoff_r, cmd_r};
	`CCS_OFS_CTRL: rd_mux = {21'h0, ctrl_r};
	`CCS_OFS_IRQ: rd_mux = {25'h0, irq_r};
	`CCS_OFS_ERR: rd_mux = {30'h0, err_r};
	`CCS_OFS_STAT: rd_mux = {27'h0, state_r[4], state_r[1], acv_r,
		tact_r, cipher_r};
	`CCS_OFS_FIFO: rd_mux = auth_act ? 32'h00000000 : {24'h0, fifo_rdata_in};
	default: rd_mux = 32'h00000000;
	endcase
end

// --------------------
// command sequencing
// --------------------
always @* begin
	state_nxt = state_r;
	cmd_nxt = cmd_r;
	cnt_nxt = cnt_r;
	len_nxt = len_r;
	first_nxt = first_r;
	drop_nxt = drop_r;
	surp_nxt = surp_r;
	started_nxt = started_r;
	acv_nxt = acv_r;
	acmode_nxt = acmode_r;
	push = 1'b0;
	pdata = rx_byte_in;
	txgo = 1'b0;
	tmgo = 1'b0;
	authgo = 1'b0;
	rx_done = 1'b0;
	send_clr = 1'b0;
	tact_set = 1'b0;
	tact_val = 1'b0;
	irq_set = {`CCS_IRQ_W{1'b0}};
	err_set = 2'b00;
	case (state_r)
	ST_RX: begin
		if (timer_expired_in & tauto) begin
			irq_set[`CCS_IRQ_TIMER] = 1'b1; // R7
		end
		if (cmd_r == `CCS_CMD_TRCV && !rf_ok) begin
			rx_done = 1'b1; // R10
		end else if (rx_byte_valid_in && !rxoff_r) begin
			if (lenmode) begin
				if (first_r) begin
					if (rx_byte_in == 8'h00) begin
						drop_nxt = 1'b1; // R5
					end else begin
						push = 1'b1;
						len_nxt = rx_byte_in;
						cnt_nxt = 8'h01;
						first_nxt = 1'b0;
						rx_done = (rx_byte_in == 8'h01); // R4
					end
				end else if (!drop_r) begin
					push = 1'b1;
					cnt_nxt = cnt_inc;
					rx_done = (cnt_inc == len_r); // R4
				end
			end else begin
				push = 1'b1;
				cnt_nxt = cnt_inc;
				first_nxt = 1'b0;
				if (first_r) begin
					len_nxt = rx_byte_in;
					cnt_nxt = 8'h01;
				end
				if (peer106 && !first_r && cnt_inc == len_r && !rx_eof_in) begin
					first_nxt = 1'b1; // R6
					surp_nxt = 1'b1;
					tmgo = tauto; // R6
				end
			end
			if (rx_eof_in && !rx_done) begin
				if (lenmode) begin
					if (drop_r || rx_byte_in == 8'h00 && first_r) begin
						drop_nxt = 1'b0; // R5
						first_nxt = 1'b1;
					end else begin
						state_nxt = ST_PAD; // R4
					end
				end else if (surp_r) begin
					surp_nxt = 1'b0; // R6
				end else begin
					rx_done = 1'b1; // R3
				end
			end
		end else if (rx_eof_in && !rxoff_r) begin
			drop_nxt = 1'b0;
			if (!lenmode && !surp_r && !first_r) begin
				rx_done = 1'b1; // R3
			end
		end
	end
	ST_PAD: begin
		push = 1'b1;
		pdata = rx_noise_in; // R4
		cnt_nxt = cnt_inc;
		rx_done = (cnt_inc == len_r);
	end
	ST_TXW: begin
		if (ctrl_r[`CCS_CTL_SEND] && rf_ok) begin
			txgo = 1'b1; // R11
			send_clr = 1'b1;
			state_nxt = ST_TX;
		end
	end
	ST_TX: begin
		if (tx_done_in) begin
			irq_set[`CCS_IRQ_TX] = 1'b1;
			state_nxt = ST_RX; // R9
		end
	end
	ST_AC: begin
		if (!rf_ok) begin
			acv_nxt = 1'b0; // R13
		end else if (mode_detected_in && !ctrl_r[`CCS_CTL_MDOFF] && !acv_r) begin
			acv_nxt = 1'b1; // R12
			acmode_nxt = mode_in;
			if (mode_in == `CCS_MODE_P106 || mode_in == `CCS_MODE_A106) begin
				push = 1'b1; // R18 R19
				pdata = `CCS_START_BYTE;
			end
		end else if (acv_r && rx_byte_valid_in) begin
			push = 1'b1;
		end else if (acv_r && ac_done_in) begin
			tact_set = 1'b1;
			tact_val = (acmode_r != `CCS_MODE_A106) & (acmode_r != `CCS_MODE_A212); // R18 R19
			irq_set[`CCS_IRQ_RX] = 1'b1; // R14
			cmd_nxt = `CCS_CMD_TRCV; // R14
			state_nxt = ST_TXW;
		end
	end
	ST_AUTH: begin
		if (!started_r && fifo_level_in >= `CCS_AUTH_BYTES) begin
			authgo = 1'b1;
			started_nxt = 1'b1;
		end
		if (timer_expired_in & tauto) begin
			irq_set[`CCS_IRQ_TIMER] = 1'b1; // R22
		end
		if (fifo_acc) begin
			err_set[`CCS_ERR_WR] = 1'b1; // R21
		end
		if (auth_err_in) begin
			err_set[`CCS_ERR_PROT] = 1'b1; // R23
		end
		if (auth_ok_in || auth_err_in) begin
			cmd_nxt = `CCS_CMD_IDLE; // R22
			state_nxt = ST_IDLE;
		end
	end
	ST_SRST: begin
		cmd_nxt = `CCS_CMD_IDLE; // R24
		state_nxt = ST_IDLE;
	end
	ST_IDLE: begin
		state_nxt = ST_IDLE;
	end
	default: begin
		state_nxt = ST_IDLE;
	end
	endcase
	if (rx_done) begin
		irq_set[`CCS_IRQ_RX] = 1'b1;
		first_nxt = 1'b1;
		surp_nxt = 1'b0;
		drop_nxt = 1'b0;
		if (multi) begin
			state_nxt = ST_RX; // R8
		end else if (cmd_r == `CCS_CMD_TRCV) begin
			state_nxt = ST_TXW; // R9
		end else begin
			cmd_nxt = `CCS_CMD_IDLE; // R3
			state_nxt = ST_IDLE;
		end
	end
	if (state_r != ST_IDLE && state_nxt == ST_IDLE) begin
		irq_set[`CCS_IRQ_IDLE] = 1'b1;
	end
	if (rf_ok & ~rf_d_r) begin
		irq_set[`CCS_IRQ_RFON] = 1'b1;
	end
	if (~rf_ok & rf_d_r) begin
		irq_set[`CCS_IRQ_RFOFF] = 1'b1;
	end
	if (~sig_ok & sig_d_r) begin
		irq_set[`CCS_IRQ_SIGIN] = 1'b1;
	end
	if (auth_act) begin
		irq_set[`CCS_IRQ_RX] = 1'b0; // R21
		irq_set[`CCS_IRQ_TX] = 1'b0;
	end
	if (cmd_wr) begin
		cmd_nxt = wr_code; // R25 R1
		first_nxt = 1'b1;
		drop_nxt = 1'b0;
		surp_nxt = 1'b0;
		started_nxt = 1'b0;
		acv_nxt = 1'b0; // R17
		txgo = 1'b0;
		authgo = 1'b0;
		push = 1'b0;
		case (wr_code)
		`CCS_CMD_RECV: begin
			state_nxt = ST_RX;
			tmgo = tauto;
		end
		`CCS_CMD_TRCV: begin
			state_nxt = ctrl_r[`CCS_CTL_INIT] ? ST_TXW : ST_RX; // R9
			tmgo = tauto & ~ctrl_r[`CCS_CTL_INIT];
		end
		`CCS_CMD_ACOL: state_nxt = ST_AC; // R12
		`CCS_CMD_AUTH: state_nxt = ST_AUTH;
		`CCS_CMD_SRST: state_nxt = ST_SRST; // R24
		default: begin
			cmd_nxt = `CCS_CMD_IDLE;
			state_nxt = ST_IDLE;
		end
		endcase
	end
end

// --------------------
// registers and outputs
// --------------------
always @(posedge clock_in or negedge reset_n_in) begin
	if (!reset_n_in) begin
		state_r <= ST_IDLE;
		cmd_r <= `CCS_CMD_IDLE;
		rxoff_r <= 1'b0;
		pdown_r <= 1'b0;
		ctrl_r <= `CCS_CTL_RST;
		irq_r <= {`CCS_IRQ_W{1'b0}};
		err_r <= 2'b00;
		cipher_r <= 1'b0;
		tact_r <= 1'b0;
		cnt_r <= 8'h00;
		len_r <= 8'h00;
		first_r <= 1'b1;
		drop_r <= 1'b0;
		surp_r <= 1'b0;
		started_r <= 1'b0;
		acv_r <= 1'b0;
		acmode_r <= 3'h0;
		rf_d_r <= 1'b0;
		sig_d_r <= 1'b0;
		prdata_out <= 32'h00000000;
		pready_out <= 1'b0;
		pslverr_out <= 1'b0;
		rx_enable_out <= 1'b0;
		tx_start_out <= 1'b0;
		timer_start_out <= 1'b0;
		mode_detect_en_out <= 1'b0;
		tx_crc_en_out <= 1'b0;
		rx_crc_en_out <= 1'b0;
		crc_keep_out <= 1'b0;
		auth_start_out <= 1'b0;
		fifo_push_out <= 1'b0;
		fifo_wdata_out <= 8'h00;
		fifo_pop_out <= 1'b0;
		soft_reset_out <= 1'b0;
		power_down_out <= 1'b0;
	end else begin
		// no wait state: pready rises in the first access cycle
		pready_out <= psel_in & ~penable_in & ~pready_out;
		if (psel_in & ~penable_in) begin
			prdata_out <= rd_mux;
			pslverr_out <= ~addr_hit;
		end
		state_r <= state_nxt;
		cmd_r <= cmd_nxt;
		cnt_r <= cnt_nxt;
		len_r <= len_nxt;
		first_r <= first_nxt;
		drop_r <= drop_nxt;
		surp_r <= surp_nxt;
		started_r <= started_nxt;
		acv_r <= acv_nxt;
		acmode_r <= acmode_nxt;
		rf_d_r <= rf_ok;
		sig_d_r <= sig_ok;
		// set wins over a same-cycle write-one clear
		irq_r <= (irq_r & ~((apb_wr && paddr_in == `CCS_OFS_IRQ) ?
			pwdata_in[`CCS_IRQ_W-1:0] : {`CCS_IRQ_W{1'b0}})) | irq_set;
		err_r <= (err_r & ~((apb_wr && paddr_in == `CCS_OFS_ERR) ?
			pwdata_in[1:0] : 2'b00)) | err_set;
		if (apb_wr && paddr_in == `CCS_OFS_CMD) begin
			rxoff_r <= pwdata_in[`CCS_CMD_RXOFF]; // R2
			pdown_r <= pwdata_in[`CCS_CMD_PDOWN];
		end
		if (apb_wr && paddr_in == `CCS_OFS_CTRL) begin
			ctrl_r <= pwdata_in[`CCS_CTL_W-1:0];
		end else if (send_clr) begin
			ctrl_r[`CCS_CTL_SEND] <= 1'b0;
		end
		if (auth_ok_in & auth_act) begin
			cipher_r <= 1'b1; // R22
		end else if (auth_err_in & auth_act) begin
			cipher_r <= 1'b0; // R23
		end
		if (tact_set) begin
			tact_r <= tact_val;
		end
		rx_enable_out <= (state_nxt == ST_RX || state_nxt == ST_AC) & ~rxoff_r & rf_ok;
		tx_start_out <= txgo;
		timer_start_out <= tmgo;
		auth_start_out <= authgo;
		mode_detect_en_out <= (state_nxt == ST_AC) & ~ctrl_r[`CCS_CTL_MDOFF] & ~acv_nxt;
		crc_keep_out <= (state_nxt == ST_AC) & acv_nxt & acm_106 & ~ac_ran_in; // R16
		if (state_r == ST_AC && acv_r && acm_a) begin
			tx_crc_en_out <= `CCS_AC_A_CRC; // R15
			rx_crc_en_out <= `CCS_AC_A_CRC;
		end else begin
			tx_crc_en_out <= ctrl_r[`CCS_CTL_TXCRC]; // R15
			rx_crc_en_out <= ctrl_r[`CCS_CTL_RXCRC];
		end
		fifo_push_out <= push | (fifo_acc & pwrite_in & ~auth_act); // R21
		fifo_wdata_out <= push ? pdata : pwdata_in[7:0];
		fifo_pop_out <= fifo_acc & ~pwrite_in & ~auth_act;
		power_down_out <= pdown_r;
		soft_reset_out <= (state_r == ST_SRST);
		if (state_r == ST_SRST) begin
			// register reset values come back; the external config buffer is untouched
			ctrl_r <= `CCS_CTL_RST; // R24
			irq_r <= {`CCS_IRQ_W{1'b0}};
			err_r <= 2'b00;
			rxoff_r <= 1'b0;
			pdown_r <= 1'b0;
			cipher_r <= 1'b0;
			tact_r <= 1'b0;
		end
	end
end

endmodule

//--- verification/ccs_sequencer_asserts.sv
// port assertions of the command sequencer
`timescale 1ns/1ps
`include "ccs_map.vh"
module ccs_sequencer_asserts (
	// clock and reset
	input wire clock_in,
	input wire reset_n_in,
	// apb
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [7:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire pready_out,
	// datapath and engines
	input wire rx_byte_valid_in,
	input wire rx_eof_in,
	input wire rf_field_in,
	input wire auth_ok_in,
	input wire auth_err_in,
	input wire rx_enable_out,
	input wire tx_start_out,
	input wire mode_detect_en_out,
	input wire auth_start_out,
	input wire fifo_push_out,
	input wire soft_reset_out,
	input wire power_down_out
);
// --------------------
// shadow state
// --------------------
wire acc = psel_in && penable_in && pready_out;
wire wr_cmd = acc && pwrite_in && paddr_in == `CCS_OFS_CMD;
wire [3:0] code = pwdata_in[3:0];
reg [2:0] fon_r;
reg [10:0] ctrl_r;
reg auth_r;
always @(posedge clock_in or negedge reset_n_in) begin
	if (!reset_n_in) begin
		fon_r <= 3'h0;
		ctrl_r <= `CCS_CTL_RST;
		auth_r <= 1'b0;
	end else begin
		// seven cycles of field cover the input synchroniser delay
		fon_r <= !rf_field_in ? 3'h0 : (fon_r == 3'h7 ? fon_r : fon_r + 3'h1);
		if (wr_cmd && code == `CCS_CMD_SRST)
			ctrl_r <= `CCS_CTL_RST;
		else if (acc && pwrite_in && paddr_in == `CCS_OFS_CTRL)
			ctrl_r <= pwdata_in[10:0];
		if (wr_cmd && code != `CCS_CMD_KEEP)
			auth_r <= code == `CCS_CMD_AUTH;
		else if (auth_ok_in || auth_err_in)
			auth_r <= 1'b0;
	end
end
default clocking @(posedge clock_in); endclocking
default disable iff (!reset_n_in);
// --------------------
// properties
// --------------------
chk_recv_path: assert property (wr_cmd && code == `CCS_CMD_RECV && fon_r == 3'h7
	|-> ##[1:2] rx_enable_out) else $error("receiver not enabled");
chk_keep_power: assert property (wr_cmd && code == `CCS_CMD_KEEP
	|=> ##1 power_down_out == $past(pwdata_in[`CCS_CMD_PDOWN], 2)) else $error("power bit lost");
chk_keep_recv: assert property (wr_cmd && code == `CCS_CMD_KEEP && rx_enable_out
	&& fon_r == 3'h7 && !rx_eof_in && !rx_byte_valid_in |=> rx_enable_out)
	else $error("keep code stopped reception");
chk_auth_block: assert property (auth_r && acc && paddr_in == `CCS_OFS_FIFO
	|=> !fifo_push_out) else $error("fifo written during authentication");
chk_soft_reset: assert property (wr_cmd && code == `CCS_CMD_SRST
	|-> ##[1:2] soft_reset_out) else $error("soft reset missing");
chk_no_field: assert property (!rf_field_in [*8] |-> !rx_enable_out && !tx_start_out)
	else $error("activity without field");
chk_detect_on: assert property (wr_cmd && code == `CCS_CMD_ACOL && fon_r == 3'h7
	&& !ctrl_r[`CCS_CTL_MDOFF] |-> ##[1:3] mode_detect_en_out) else $error("no detector");
chk_send_first: assert property (wr_cmd && code == `CCS_CMD_TRCV && fon_r == 3'h7
	&& ctrl_r[`CCS_CTL_INIT] && ctrl_r[`CCS_CTL_SEND] |-> ##[1:4] tx_start_out)
	else $error("initiator did not send first");
chk_abort_idle: assert property (wr_cmd && code == `CCS_CMD_IDLE
	|-> ##[1:2] !rx_enable_out && !mode_detect_en_out) else $error("abort ignored");
cov_recv: cover property (rx_enable_out && fifo_push_out);
cov_send: cover property (tx_start_out);
cov_auth: cover property (auth_start_out);
cov_srst: cover property (soft_reset_out);
endmodule
bind ccs_sequencer ccs_sequencer_asserts u_chk (.*);

//--- verification/ccs_rf_peer.sv
// far-side model: peer that sends frames and finishes transmissions
`timescale 1ns/1ps
module ccs_rf_peer (
	// clock and reset
	input wire clock_in,
	input wire reset_n_in,
	// bench control
	input wire send_in,
	input wire [7:0] len_in,
	input wire [7:0] cnt_in,
	input wire [3:0] gap_in,
	output wire busy_out,
	// sequencer side
	input wire tx_start_in,
	output reg rx_byte_valid_out,
	output reg [7:0] rx_byte_out,
	output reg rx_eof_out,
	output reg tx_done_out
);
reg [7:0] left_r, idx_r, td_r;
reg [3:0] wait_r;
assign busy_out = left_r != 8'h00;
always @(posedge clock_in or negedge reset_n_in) begin
	if (!reset_n_in) begin
		left_r <= 8'h00;
		idx_r <= 8'h00;
		td_r <= 8'h00;
		wait_r <= 4'h0;
		rx_byte_valid_out <= 1'b0;
		rx_byte_out <= 8'h00;
		rx_eof_out <= 1'b0;
		tx_done_out <= 1'b0;
	end else begin
		rx_byte_valid_out <= 1'b0;
		rx_eof_out <= 1'b0;
		tx_done_out <= 1'b0;
		// the data lines toggle between bytes so a stale byte never looks valid
		rx_byte_out <= ~rx_byte_out;
		if (send_in) begin
			left_r <= cnt_in;
			idx_r <= 8'h00;
			wait_r <= 4'h0;
		end else if (busy_out && wait_r != gap_in) begin
			wait_r <= wait_r + 4'h1;
		end else if (busy_out) begin
			wait_r <= 4'h0;
			left_r <= left_r - 8'h01;
			idx_r <= idx_r + 8'h01;
			rx_byte_valid_out <= 1'b1;
			rx_byte_out <= idx_r == 8'h00 ? len_in : idx_r + 8'h30;
			rx_eof_out <= left_r == 8'h01;
		end
		// gap selects a prompt or a slow end of transmission
		if (tx_start_in)
			td_r <= {4'h0, gap_in} + 8'h02;
		else if (td_r != 8'h00) begin
			td_r <= td_r - 8'h01;
			tx_done_out <= td_r == 8'h01;
		end
	end
end
endmodule

//--- verification/contactless_command_sequencer_bench.sv
// self-checking bench of the command sequencer
`timescale 1ns/1ps
`include "ccs_map.vh"
module contactless_command_sequencer_bench;
reg clock_in = 1'b0;
reg reset_n_in = 1'b0;
reg psel_in, penable_in, pwrite_in, p_send, rf_field_in, sig_active_in, timer_expired_in;
reg mode_detected_in, ac_done_in, ac_ran_in, auth_ok_in, auth_err_in;
reg [7:0] paddr_in, rx_noise_in, fifo_rdata_in, p_len, p_cnt;
reg [31:0] pwdata_in, rd;
reg [3:0] p_gap;
reg [2:0] mode_in;
reg [6:0] fifo_level_in;
reg err;
reg [7:0] q[$];
wire [31:0] prdata_out;
wire [7:0] rx_byte_in, fifo_wdata_out;
wire pready_out, pslverr_out, rx_byte_valid_in, rx_eof_in, tx_done_in, rx_enable_out;
wire tx_start_out, timer_start_out, mode_detect_en_out, tx_crc_en_out, rx_crc_en_out;
wire crc_keep_out, auth_start_out, fifo_push_out, fifo_pop_out, soft_reset_out;
wire power_down_out, p_busy;
integer n_fail = 0, total_checks = 0, seed = 99, i, m, k;
always #2.5 clock_in = ~clock_in;
always @(posedge clock_in) if (fifo_push_out === 1'b1) q.push_back(fifo_wdata_out);
ccs_sequencer DUT (.*);
ccs_rf_peer u_peer (.clock_in, .reset_n_in, .send_in(p_send), .len_in(p_len), .cnt_in(p_cnt),
	.gap_in(p_gap), .busy_out(p_busy), .tx_start_in(tx_start_out),
	.rx_byte_valid_out(rx_byte_valid_in), .rx_byte_out(rx_byte_in),
	.rx_eof_out(rx_eof_in), .tx_done_out(tx_done_in));
// --------------------
// tasks and expectations
// --------------------
task finish_test;
	if (n_fail == 0 && total_checks > 0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish;
endtask
task chk(input [31:0] g, input [31:0] e);
	total_checks++;
	if (g !== e) begin
		n_fail++;
		$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
	end
endtask
task apb(input w, input [7:0] a, input [31:0] d);
	integer n;
	n = 0;
	@(posedge clock_in);
	psel_in <= 1'b1;
	penable_in <= 1'b0;
	pwrite_in <= w;
	paddr_in <= a;
	pwdata_in <= d;
	@(posedge clock_in);
	penable_in <= 1'b1;
	do @(posedge clock_in); while (pready_out !== 1'b1 && n++ < 40);
	if (n > 40) begin
		n_fail++;
		finish_test;
	end
	rd = prdata_out;
	err = pslverr_out;
	psel_in <= 1'b0;
	penable_in <= 1'b0;
endtask
task wr(input [7:0] a, input [31:0] d);
	apb(1'b1, a, d);
endtask
task rc(input [7:0] a, input [31:0] mk, input [31:0] e);
	apb(1'b0, a, 32'h0);
	chk(rd & mk, e);
endtask
task cyc(input integer n);
	repeat (n) @(posedge clock_in);
endtask
task frame(input [7:0] l, input [7:0] c, input [3:0] g);
	integer j;
	p_len <= l;
	p_cnt <= c;
	p_gap <= g;
	p_send <= 1'b1;
	@(posedge clock_in);
	p_send <= 1'b0;
	cyc(2);
	for (j = 0; j < 400 && p_busy; j++) @(posedge clock_in);
	cyc(12);
endtask
function [7:0] fbyte(input integer i, input [7:0] l);
	fbyte = i == 0 ? l : i + 8'h30;
endfunction
function tgt(input integer m);
	tgt = !(m == 2 || m == 3);
endfunction
// --------------------
// scenarios
// --------------------
initial begin
	{psel_in, penable_in, pwrite_in, p_send, timer_expired_in, mode_detected_in} = 6'h00;
	{ac_done_in, auth_ok_in, auth_err_in, rf_field_in} = 4'h0;
	{sig_active_in, ac_ran_in} = 2'h3;
	{paddr_in, pwdata_in, p_len, p_cnt, p_gap, mode_in, fifo_level_in} = 0;
	fifo_rdata_in = $random(seed);
	rx_noise_in = $random(seed);
	cyc(2);
	reset_n_in <= 1'b1;
	rf_field_in <= 1'b1;
	cyc(8);
	rc(`CCS_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
	rc(`CCS_OFS_STAT, 32'h3, 32'h0);
	rc(8'h18, 32'hFFFFFFFF, 32'h0);
	chk(err, 1'b1);
	for (i = 0; i < 4; i++) begin
		m = i == 0 ? 0 : (i == 1 ? 8 : 12 + i - 2);
		wr(`CCS_OFS_CMD, m);
		rc(`CCS_OFS_CMD, 32'hF, m);
		wr(`CCS_OFS_CMD, `CCS_CMD_IDLE);
	end
	for (i = 0; i < 4; i++) begin
		m = 2 + {$random(seed)} % 5;
		wr(`CCS_OFS_IRQ, 32'h7F);
		wr(`CCS_OFS_CMD, `CCS_CMD_RECV);
		q.delete();
		frame(m, m, i);
		chk(q.size(), m);
		for (k = 0; k < m; k++) chk(q[k], fbyte(k, m));
		rc(`CCS_OFS_CMD, 32'hF, `CCS_CMD_IDLE);
		rc(`CCS_OFS_IRQ, 32'h6, 32'h6);
	end
	wr(`CCS_OFS_CMD, `CCS_CMD_RECV);
	wr(`CCS_OFS_CMD, 32'h27);
	rc(`CCS_OFS_CMD, 32'h3F, 32'h28);
	chk(rx_enable_out, 1'b1);
	chk(power_down_out, 1'b1);
	wr(`CCS_OFS_CTRL, 32'h4);
	timer_expired_in <= 1'b1;
	@(posedge clock_in);
	timer_expired_in <= 1'b0;
	rc(`CCS_OFS_IRQ, 32'h1, 32'h1);
	rc(`CCS_OFS_CMD, 32'hF, `CCS_CMD_RECV);
	wr(`CCS_OFS_CMD, `CCS_CMD_IDLE);
	cyc(2);
	chk(rx_enable_out, 1'b0);
	wr(`CCS_OFS_CTRL, 32'h2);
	wr(`CCS_OFS_CMD, `CCS_CMD_RECV);
	frame(3, 3, 1);
	rc(`CCS_OFS_CMD, 32'hF, `CCS_CMD_RECV);
	wr(`CCS_OFS_CMD, `CCS_CMD_IDLE);
	wr(`CCS_OFS_CTRL, 32'h280);
	wr(`CCS_OFS_CMD, `CCS_CMD_RECV);
	frame(0, 2, 0);
	rc(`CCS_OFS_CMD, 32'hF, `CCS_CMD_RECV);
	q.delete();
	frame(4, 6, 0);
	rc(`CCS_OFS_CMD, 32'hF, `CCS_CMD_IDLE);
	chk(q.size(), 4);
	wr(`CCS_OFS_CMD, `CCS_CMD_RECV);
	q.delete();
	frame(5, 3, 0);
	chk(q.size(), 5);
	chk(q[4], rx_noise_in);
	wr(`CCS_OFS_CTRL, 32'h41);
	wr(`CCS_OFS_IRQ, 32'h7F);
	wr(`CCS_OFS_CMD, `CCS_CMD_TRCV);
	cyc(10);
	frame(2, 2, 2);
	rc(`CCS_OFS_IRQ, 32'hC, 32'hC);
	rc(`CCS_OFS_CMD, 32'hF, `CCS_CMD_TRCV);
	rf_field_in <= 1'b0;
	cyc(10);
	chk(rx_enable_out, 1'b0);
	rf_field_in <= 1'b1;
	cyc(8);
	wr(`CCS_OFS_CMD, `CCS_CMD_IDLE);
	wr(`CCS_OFS_CTRL, 32'h0);
	wr(`CCS_OFS_CMD, `CCS_CMD_TRCV);
	cyc(3);
	chk(rx_enable_out, 1'b1);
	wr(`CCS_OFS_CMD, `CCS_CMD_ACOL);
	rf_field_in <= 1'b0;
	cyc(10);
	rc(`CCS_OFS_CMD, 32'hF, `CCS_CMD_ACOL);
	rf_field_in <= 1'b1;
	cyc(8);
	for (m = 0; m < 6; m++) begin
		wr(`CCS_OFS_CTRL, 32'h30);
		wr(`CCS_OFS_CMD, `CCS_CMD_ACOL);
		cyc(2);
		chk(mode_detect_en_out, 1'b1);
		q.delete();
		mode_in <= m;
		mode_detected_in <= 1'b1;
		@(posedge clock_in);
		mode_detected_in <= 1'b0;
		cyc(3);
		if (m >= 4) chk(tx_crc_en_out, m == 5);
		if (m >= 4) chk(rx_crc_en_out, m == 5);
		ac_done_in <= 1'b1;
		@(posedge clock_in);
		ac_done_in <= 1'b0;
		cyc(3);
		if (m == 0 || m == 2) chk(q.size() ? q[0] : 8'h00, `CCS_START_BYTE);
		rc(`CCS_OFS_STAT, 32'h2, tgt(m) << 1);
		rc(`CCS_OFS_CMD, 32'hF, `CCS_CMD_TRCV);
		wr(`CCS_OFS_CMD, `CCS_CMD_IDLE);
	end
	for (i = 0; i < 12; i++) wr(`CCS_OFS_FIFO, i ? i : 32'h60);
	fifo_level_in <= `CCS_AUTH_BYTES;
	for (i = 0; i < 2; i++) begin
		wr(`CCS_OFS_ERR, 32'h3);
		wr(`CCS_OFS_CMD, `CCS_CMD_AUTH);
		cyc(3);
		k = q.size();
		wr(`CCS_OFS_FIFO, 32'hAB);
		cyc(2);
		chk(q.size(), k);
		rc(`CCS_OFS_ERR, 32'h1, 32'h1);
		auth_ok_in <= i == 0;
		auth_err_in <= i == 1;
		@(posedge clock_in);
		{auth_ok_in, auth_err_in} <= 2'h0;
		cyc(3);
		rc(`CCS_OFS_STAT, 32'h1, i == 0);
		rc(`CCS_OFS_ERR, 32'h2, i << 1);
		rc(`CCS_OFS_CMD, 32'hF, `CCS_CMD_IDLE);
	end
	fifo_level_in <= 7'h00;
	wr(`CCS_OFS_CTRL, 32'h155);
	wr(`CCS_OFS_CMD, `CCS_CMD_SRST);
	cyc(4);
	rc(`CCS_OFS_CTRL, 32'h7FF, 32'h0);
	rc(`CCS_OFS_CMD, 32'hF, `CCS_CMD_IDLE);
	finish_test;
end
// about 800 cycles are needed
initial begin
	#400000;
	n_fail++;
	finish_test;
end
endmodule
